// >>> bench/aih_fw_model.sv
// Firmware model answering the motion commands of the handshake core
`timescale 1ns/1ps
module aih_fw_model
   import aih_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire aih_cmd_s cmd,
   input wire logic motion_active,
   input wire logic slow,
   output logic fw_halt_ack,
   output logic motion_done,
   output logic settled
);
   logic [7:0] run_r;
   logic [7:0] set_r;
   logic stop_r;
   logic halt_r;
   logic act_r;
   // firmware stops the motor, then reports it
   always_ff @(posedge clock) begin
      if (srst) begin
         run_r <= 8'h00;
         stop_r <= 1'b0;
         halt_r <= 1'b0;
         motion_done <= 1'b0;
         fw_halt_ack <= 1'b0;
      end else begin
         stop_r <= cmd.stop;
         motion_done <= 1'b0;
         fw_halt_ack <= 1'b0;
         if (cmd.start || cmd.home) begin
            run_r <= slow ? 8'h28 : 8'h08;
            halt_r <= 1'b0;
         end else if (cmd.stop && !stop_r) begin
            // Stop command lasts one cycle, so the halt is remembered until the motor is down
            run_r <= slow ? 8'h14 : 8'h04;
            halt_r <= 1'b1;
         end else if (run_r == 8'h01) begin
            run_r <= 8'h00;
            halt_r <= 1'b0;
            fw_halt_ack <= halt_r;
            motion_done <= !halt_r;
         end else if (run_r != 8'h00) begin
            run_r <= run_r - 8'h01;
         end
      end
   end
   // settling time varies with load, so slow mode stretches it
   always_ff @(posedge clock) begin
      if (srst) begin
         set_r <= 8'h00;
         act_r <= 1'b0;
         settled <= 1'b0;
      end else begin
         act_r <= motion_active;
         settled <= (set_r == 8'h01);
         if (act_r && !motion_active) begin
            set_r <= slow ? 8'h14 : 8'h03;
         end else if (set_r != 8'h00) begin
            set_r <= set_r - 8'h01;
         end
      end
   end
endmodule : aih_fw_model

// >>> bench/test_actuator_io_handshake.sv
// Self-checking bench for the actuator I/O handshake core
`timescale 1ns/1ps
module test_actuator_io_handshake
   import aih_pkg::*;
;
   logic clock = 1'b0;
   logic srst = 1'b1;
   aih_in_s pins = 8'h03;
   logic [SEL_W-1:0] select_in = 6'h00;
   logic driver_mode = 1'b0;
   aih_stop_e stop_action = AIH_STOP_IMM;
   logic slow = 1'b0;
   logic fw_halt_ack, motion_done, settled, motion_active, in_position;
   logic step_fwd, step_rev, excited, brake_released;
   aih_cmd_s cmd;
   int err_count = 0;
   int check_count = 0;
   always #50 clock = ~clock;
   aih_core #(.BRK_REL_T(40), .BRK_HOLD_T(20), .DEEXC_T(40), .REEXC_T(20)) dut (.clock(clock), .srst(srst),
      .pins(pins), .select_in(select_in), .driver_mode(driver_mode), .stop_action(stop_action),
      .fw_halt_ack(fw_halt_ack), .motion_done(motion_done), .settled(settled), .cmd(cmd),
      .motion_active(motion_active), .in_position(in_position), .step_fwd(step_fwd), .step_rev(step_rev),
      .excited(excited), .brake_released(brake_released));
   aih_fw_model fw (.clock(clock), .srst(srst), .cmd(cmd), .motion_active(motion_active), .slow(slow),
      .fw_halt_ack(fw_halt_ack), .motion_done(motion_done), .settled(settled));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   function automatic logic pick(input int s);
      case (s)
         0: return motion_active;
         1: return in_position;
         2: return excited;
         3: return brake_released;
         4: return cmd.start | cmd.home;
         default: return cmd.stop;
      endcase
   endfunction : pick
   // Bounded wait, so a stuck output fails instead of hanging
   task automatic await(input int s, input logic v, input int lim, input string msg);
      int n;
      n = 0;
      #1;
      while (pick(s) !== v && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(pick(s) === v, msg);
   endtask : await
   task automatic hold(input int s, input logic v, input int cyc, input string msg);
      logic ok;
      ok = 1'b1;
      repeat (cyc) begin
         @(posedge clock);
         #1;
         if (pick(s) !== v) ok = 1'b0;
      end
      check(ok, msg);
   endtask : hold
   task automatic do_reset();
      @(posedge clock);
      srst <= 1'b1;
      pins <= 8'h03;
      driver_mode <= 1'b0;
      stop_action <= AIH_STOP_IMM;
      slow <= 1'b0;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
   endtask : do_reset
   task automatic launch(input logic home, input logic [SEL_W-1:0] idx);
      @(posedge clock);
      if (home) pins.origin_request <= 1'b1;
      else pins.move_request <= 1'b1;
      await(4, 1'b1, 12, "no start command");
      if (!home) check(cmd.index === idx && cmd.seq === (idx == SEQ_INDEX), "index or seq");
      await(0, 1'b1, 4, "motion-active late");
      check(in_position === 1'b0, "in-position kept");
      @(posedge clock);
      pins.origin_request <= 1'b0;
      pins.move_request <= 1'b0;
   endtask : launch
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_move(input logic home, input logic [SEL_W-1:0] idx);
      @(posedge clock);
      select_in <= idx;
      repeat (6) @(posedge clock);
      launch(home, idx);
      select_in <= ~idx;
      await(0, 1'b0, 60, "move never ends");
      check(in_position === 1'b0 && (home || cmd.index === idx), "latch or end order");
      await(1, 1'b1, 30, "no in-position");
   endtask : t_move
   task automatic t_halt(input aih_stop_e sa);
      do_reset();
      stop_action <= sa;
      slow <= 1'b1;
      select_in <= 6'h05;
      launch(1'b0, 6'h05);
      pins.halt_request <= 1'b1;
      await(5, 1'b1, 12, "no stop command");
      check(cmd.decel === sa[0], "stop kind");
      await(0, 1'b0, 40, "halt not ended");
      check(in_position === 1'b0, "in-position early");
      @(posedge clock);
      pins.halt_request <= 1'b0;
      await(1, 1'b1, 40, "no in-position after halt");
      await(2, !sa[1], 45, "current-off kind");
   endtask : t_halt
   task automatic t_pulse();
      int nf;
      int nr;
      driver_mode <= 1'b1;
      for (int d = 0; d < 2; d++) begin
         nf = 0;
         nr = 0;
         @(posedge clock);
         if (d == 0) pins.pulse_fwd_n <= 1'b0;
         else pins.pulse_rev_n <= 1'b0;
         repeat (12) begin
            @(posedge clock);
            #1;
            nf += (step_fwd === 1'b1);
            nr += (step_rev === 1'b1);
         end
         @(posedge clock);
         pins.pulse_fwd_n <= 1'b1;
         pins.pulse_rev_n <= 1'b1;
         check(nf == (d == 0) && nr == (d == 1), "step count");
      end
   endtask : t_pulse
   initial begin
      fork
         begin
            repeat (30000) @(posedge clock);
            err_count++;
            summarize();
         end
      join_none
      do_reset();
      @(posedge clock);
      #1;
      check(cmd === '0 && motion_active === 1'b0 && excited === 1'b1 && brake_released === 1'b0, "reset");
      await(1, 1'b1, 3, "idle in-position");
      t_move(1'b0, 6'h01);
      t_move(1'b0, 6'h3F);
      t_move(1'b0, 6'h00);
      t_move(1'b0, 6'h2A);
      t_move(1'b1, 6'h00);
      for (int k = 0; k < 4; k++) t_halt(aih_stop_e'(k));
      do_reset();
      driver_mode <= 1'b1;
      stop_action <= AIH_STOP_IMM_OFF;
      slow <= 1'b1;
      launch(1'b1, 6'h00);
      pins.origin_halt_request <= 1'b1;
      await(0, 1'b0, 40, "origin halt ignored");
      @(posedge clock);
      pins.origin_halt_request <= 1'b0;
      hold(2, 1'b1, 30, "origin halt cut current");
      @(posedge clock);
      pins.move_request <= 1'b1;
      hold(0, 1'b0, 20, "move in driver mode");
      @(posedge clock);
      pins.move_request <= 1'b0;
      t_pulse();
      do_reset();
      pins.free_run <= 1'b1;
      await(2, 1'b0, 40, "free-run excitation");
      await(3, 1'b1, 40, "free-run brake");
      @(posedge clock);
      pins.free_run <= 1'b0;
      await(2, 1'b1, 20, "re-excite late");
      await(3, 1'b0, 20, "brake hold late");
      @(posedge clock);
      driver_mode <= 1'b1;
      pins.current_cutoff <= 1'b1;
      await(2, 1'b0, 40, "cutoff excitation");
      hold(3, 1'b0, 30, "cutoff freed brake");
      @(posedge clock);
      pins.free_run <= 1'b1;
      await(3, 1'b1, 40, "brake release late");
      @(posedge clock);
      pins.free_run <= 1'b0;
      await(3, 1'b0, 20, "brake hold late");
      check(excited === 1'b0, "cutoff lost");
      summarize();
   end
endmodule : test_actuator_io_handshake

// >>> core/aih_core.sv
// Discrete I/O handshake of a linear actuator controller
`timescale 1ns/1ps
// Notes on behaviour
// R1: Input or output is asserted while its photocoupler conducts.
// R2: Host holds origin request over 4 ms or until motion-active asserts.
// R3: Host holds move request over 4 ms or until motion-active asserts.
// R4: Six select inputs form binary entry index 0 to 63, bit5 most significant.
// R5: Index zero runs sequential operation instead of a single entry.
// R6: In-position asserts after a move ends, after a variable delay.
// R7: Host holds halt over 4 ms or until motion-active deasserts.
// R8: Halt stops motor, then drops motion-active, then raises in-position.
// R9: Halt requests go through firmware, not a direct hardware path.
// R10: Pulse command inputs are active low in driver mode.
// R11: When de-excited, free-run releases brake within 150 ms, re-holds within 25 ms.
// R12: When excited, free-run de-excites within 100 ms, re-excites within 6 ms.
// R13: Free-run de-excites and releases brake; cutoff de-excites and holds brake. The core acts on cutoff only in driver mode.
// R14: Halt follows configured stop action; origin-halt never uses current-off variants.
// R15: Halt acts in controller mode; origin-halt stops origin search in driver mode.
// R16: Motion-active stands for whole move; in-position drops when a move starts.
// R17: Select inputs are latched when a move request is accepted.
module aih_core
   import aih_pkg::*;
#(
   parameter int BRK_REL_T = BRK_REL_CYC,
   parameter int BRK_HOLD_T = BRK_HOLD_CYC,
   parameter int DEEXC_T = DEEXC_CYC,
   parameter int REEXC_T = REEXC_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input aih_in_s pins,
   input wire logic [SEL_W-1:0] select_in,
   input wire logic driver_mode,
   input wire aih_stop_e stop_action,
   input wire logic fw_halt_ack,
   input wire logic motion_done,
   input wire logic settled,
   output aih_cmd_s cmd,
   output logic motion_active,
   output logic in_position,
   output logic step_fwd,
   output logic step_rev,
   output logic excited,
   output logic brake_released
);
   // ****************************************
   // Input conditioning
   // ****************************************
   aih_in_s sp;
   logic [SEL_W-1:0] ssel;

   // R1 conducting maps to logic one
   aih_sync #(.W($bits(aih_in_s))) u_sync_pins (
      .clock(clock),
      .srst(srst),
      .din(pins),
      .dout(sp)
   );
   aih_sync #(.W(SEL_W)) u_sync_sel (
      .clock(clock),
      .srst(srst),
      .din(select_in),
      .dout(ssel)
   );

   logic org_q_r;
   logic mov_q_r;
   logic pf_q_r;
   logic pr_q_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         org_q_r <= 1'b0;
         mov_q_r <= 1'b0;
         pf_q_r <= 1'b0;
         pr_q_r <= 1'b0;
      end else begin
         org_q_r <= sp.origin_request;
         mov_q_r <= sp.move_request;
         pf_q_r <= sp.pulse_fwd_n;
         pr_q_r <= sp.pulse_rev_n;
      end
   end
   // R2 rising edge of held origin request starts a search
   wire org_rise = sp.origin_request & ~org_q_r;
   // R3 rising edge of held move request starts a positioning move
   wire mov_rise = sp.move_request & ~mov_q_r & ~driver_mode;
   // R10 step is a falling pulse edge; history resets low so leaving reset is no step
   wire pf_step = ~sp.pulse_fwd_n & pf_q_r;
   wire pr_step = ~sp.pulse_rev_n & pr_q_r;

   // ****************************************
   // Motion sequencer
   // ****************************************
   aih_state_e st_r;
   logic deexc_r;
   logic halt_req;
   logic halt_off;
   always_comb begin
      halt_req = 1'b0;
      halt_off = 1'b0;
      // R15 halt in controller mode, origin-halt only during driver-mode search
      if (sp.halt_request && !driver_mode) begin
         halt_req = 1'b1;
         // R14 current-off variants only via the halt input
         halt_off = stop_action[1];
      end else if (sp.origin_halt_request && driver_mode && st_r == AIH_HOME) begin
         halt_req = 1'b1;
      end
   end

   wire moving = (st_r == AIH_HOME) || (st_r == AIH_MOVE) || (st_r == AIH_PULSE);
   wire can_start = (st_r == AIH_IDLE || st_r == AIH_SETTLE) && !deexc_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         st_r <= AIH_IDLE;
      end else begin
         unique case (st_r)
            AIH_IDLE, AIH_SETTLE: begin
               if (can_start && org_rise) begin
                  st_r <= AIH_HOME;
               end else if (can_start && mov_rise) begin
                  st_r <= AIH_MOVE;
               end else if (can_start && driver_mode && (pf_step || pr_step)) begin
                  st_r <= AIH_PULSE;
               end else if (st_r == AIH_SETTLE && settled) begin
                  st_r <= AIH_IDLE;
               end
            end
            AIH_HOME, AIH_MOVE, AIH_PULSE: begin
               // R9 halt is handed to firmware, which acknowledges the stop
               if (halt_req || deexc_r) begin
                  st_r <= AIH_HALT;
               end else if (motion_done) begin
                  st_r <= AIH_SETTLE;
               end
            end
            AIH_HALT: begin
               // R8 motor stopped first, then motion-active drops
               if (fw_halt_ack) begin
                  st_r <= AIH_SETTLE;
               end
            end
         endcase
      end
   end

   // R17 select inputs captured when a move is accepted
   always_ff @(posedge clock) begin
      if (srst) begin
         cmd <= '0;
      end else begin
         cmd.start <= 1'b0;
         cmd.home <= 1'b0;
         if (can_start && org_rise) begin
            cmd.home <= 1'b1;
         end else if (can_start && mov_rise) begin
            cmd.start <= 1'b1;
            // R4 bit5 is the most significant select bit
            cmd.index <= ssel;
            // R5 entry zero means sequential operation
            cmd.seq <= (ssel == SEQ_INDEX);
         end
         cmd.stop <= halt_req && moving;
         cmd.decel <= (stop_action == AIH_STOP_DEC) || (stop_action == AIH_STOP_DEC_OFF);
      end
   end

   // R16 motion-active spans the move including the halt ramp
   always_ff @(posedge clock) begin
      if (srst) begin
         motion_active <= 1'b0;
      end else begin
         motion_active <= (st_r == AIH_HOME) || (st_r == AIH_MOVE) || (st_r == AIH_PULSE)
                          || (st_r == AIH_HALT);
      end
   end

   // R6 in-position only once settled after the move; R16 drops at start
   always_ff @(posedge clock) begin
      if (srst) begin
         in_position <= 1'b0;
      end else if (st_r != AIH_IDLE) begin
         in_position <= 1'b0;
      end else begin
         in_position <= 1'b1;
      end
   end

   // ****************************************
   // Pulse inputs
   // ****************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         step_fwd <= 1'b0;
         step_rev <= 1'b0;
      end else begin
         step_fwd <= driver_mode && !deexc_r && pf_step;
         step_rev <= driver_mode && !deexc_r && pr_step;
      end
   end

   // ****************************************
   // Excitation and brake
   // ****************************************
   logic cut_hold_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         cut_hold_r <= 1'b0;
      end else if (st_r == AIH_HALT && halt_off) begin
         cut_hold_r <= 1'b1;
      end else if (org_rise || mov_rise) begin
         cut_hold_r <= 1'b0;
      end
   end

   // R13 free-run or driver-mode cutoff de-excites
   wire deexc_want = sp.free_run || (sp.current_cutoff && driver_mode) || cut_hold_r;
   // R13 brake released only by free-run
   wire brk_want = sp.free_run;

   // Delays sit well inside the limits; half keeps margin for the sampling path
   logic [CNT_W-1:0] exc_cnt_r;
   logic [CNT_W-1:0] brk_cnt_r;
   always_ff @(posedge clock) begin
      if (srst) begin
         deexc_r <= 1'b0;
         exc_cnt_r <= '0;
      end else if (deexc_want == deexc_r) begin
         exc_cnt_r <= '0;
      end else begin
         exc_cnt_r <= exc_cnt_r + 1'b1;
         // R12 de-excite within 100 ms, re-excite within 6 ms
         if (exc_cnt_r >= CNT_W'((deexc_want ? DEEXC_T : REEXC_T) / 2)) begin
            deexc_r <= deexc_want;
            exc_cnt_r <= '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         brake_released <= 1'b0;
         brk_cnt_r <= '0;
      end else if (brk_want == brake_released || (brk_want && !deexc_r)) begin
         brk_cnt_r <= '0;
      end else begin
         brk_cnt_r <= brk_cnt_r + 1'b1;
         // R11 release within 150 ms, re-hold within 25 ms
         if (brk_cnt_r >= CNT_W'((brk_want ? BRK_REL_T : BRK_HOLD_T) / 2)) begin
            brake_released <= brk_want;
            brk_cnt_r <= '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         excited <= 1'b1;
      end else begin
         excited <= ~deexc_r;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence halt_seen_s;
      halt_req && moving;
   endsequence
   halt_order_a: assert property (halt_seen_s |=> st_r == AIH_HALT) // R8
      else $error("halt did not enter halt state");
   halt_cmd_a: assert property (halt_seen_s |=> cmd.stop) // R9
      else $error("halt not passed to firmware");
   start_busy_a: assert property (can_start && mov_rise |=> ##1 motion_active) // R16
      else $error("motion active missing after start");
   start_inpos_a: assert property (can_start && mov_rise |=> ##1 !in_position) // R16
      else $error("in position stayed high at start");
   sel_latch_a: assert property (can_start && mov_rise |=> cmd.index == $past(ssel)) // R17
      else $error("select not latched");
   seq_zero_a: assert property (cmd.start |-> cmd.seq == (cmd.index == SEQ_INDEX)) // R5
      else $error("sequential flag wrong");
   origin_off_a: assert property (driver_mode && !cut_hold_r |=> !cut_hold_r) // R14
      else $error("origin halt used current off");
   brake_cut_a: assert property ($rose(brake_released) |-> !excited) // R13
      else $error("brake released while excited");
   pulse_low_a: assert property (step_fwd |-> $past(!sp.pulse_fwd_n)) // R10
      else $error("step without low pulse");
   pulse_rev_a: assert property (step_rev |-> $past(!sp.pulse_rev_n)) // R10
      else $error("reverse step without low pulse");
   inpos_idle_a: assert property (in_position |-> !motion_active) // R6
      else $error("in position during motion");
endmodule : aih_core

// >>> core/aih_pkg.sv
// Package with constants and types for the actuator I/O handshake block
package aih_pkg;

   // ****************************************
   // Timing figures
   // ****************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int REQ_HOLD_MS = 4;
   localparam int BRK_REL_MS = 150;
   localparam int BRK_HOLD_MS = 25;
   localparam int DEEXC_MS = 100;
   localparam int REEXC_MS = 6;
   // Longest times round down
   localparam int REQ_HOLD_CYC = REQ_HOLD_MS * (CLK_HZ / 1000);
   localparam int BRK_REL_CYC = BRK_REL_MS * (CLK_HZ / 1000);
   localparam int BRK_HOLD_CYC = BRK_HOLD_MS * (CLK_HZ / 1000);
   localparam int DEEXC_CYC = DEEXC_MS * (CLK_HZ / 1000);
   localparam int REEXC_CYC = REEXC_MS * (CLK_HZ / 1000);

   // ****************************************
   // Fields and encodings
   // ****************************************
   localparam int SEL_W = 6;
   localparam logic [SEL_W-1:0] SEQ_INDEX = 6'h00;
   localparam int CNT_W = 24;

   typedef enum logic [1:0] {
      AIH_STOP_IMM = 2'h0,
      AIH_STOP_DEC = 2'h1,
      AIH_STOP_IMM_OFF = 2'h2,
      AIH_STOP_DEC_OFF = 2'h3
   } aih_stop_e;

   typedef enum logic [2:0] {
      AIH_IDLE = 3'h0,
      AIH_HOME = 3'h1,
      AIH_MOVE = 3'h2,
      AIH_PULSE = 3'h3,
      AIH_HALT = 3'h4,
      AIH_SETTLE = 3'h5
   } aih_state_e;

   // Raw opto inputs, high while the photocoupler conducts
   typedef struct packed {
      logic origin_request;
      logic move_request;
      logic halt_request;
      logic origin_halt_request;
      logic free_run;
      logic current_cutoff;
      logic pulse_fwd_n;
      logic pulse_rev_n;
   } aih_in_s;

   // Firmware-side motion command fields
   typedef struct packed {
      logic start;
      logic home;
      logic seq;
      logic [SEL_W-1:0] index;
      logic stop;
      logic decel;
   } aih_cmd_s;

endpackage : aih_pkg

// >>> core/aih_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module aih_sync #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clock) begin
      if (srst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge clock) begin
      if (srst) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               dout[i] <= s2_r[i];
            end
         end
      end
   end
endmodule : aih_sync
